// ==== src/sssp_pkg.sv ====
package sssp_pkg;

   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_MODE_CLOCK_CTRL = 16'hFFA0;
   localparam logic [15:0] IDX_CTRL_STATUS     = 16'hFFA1;
   localparam logic [15:0] IDX_DATA_UPPER      = 16'hFFA2;
   localparam logic [15:0] IDX_DATA_LOWER      = 16'hFFA3;
   localparam logic [15:0] IDX_INT_STATUS      = 16'hFFA4;
   localparam logic [15:0] IDX_INT_MASK        = 16'hFFA5;

   // reset values
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [7:0] STATUS_FIXED = 8'h80;
   localparam logic [7:0] DATA_RESET   = 8'h00;

   // mode/clock control fields
   localparam int CTRL_MODE_HI = 7;
   localparam int CTRL_MODE_LO = 6;
   localparam int CTRL_SRC     = 3;
   localparam int CTRL_DIV_LO  = 0;
   localparam int CTRL_DIV_W   = 3;

   // control/status fields
   localparam int STS_LEVEL   = 6;
   localparam int STS_OVERRUN = 5;
   localparam int STS_SPARE   = 1;
   localparam int STS_START   = 0;

   // interrupt status/mask fields
   localparam int INT_DONE    = 0;
   localparam int INT_OVERRUN = 1;
   localparam int INT_W       = 2;

   // word lengths in serial clock cycles
   localparam logic [4:0] LEN_8  = 5'h08;
   localparam logic [4:0] LEN_16 = 5'h10;

   // prescaler: counter width and tap bit for codes 7..0 (/2 .. /1024)
   localparam int          PRESC_W  = 10;
   localparam logic [31:0] TAP_BITS = {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h9};

   typedef enum logic [1:0] {
      SSSP_MODE_8BIT,
      SSSP_MODE_16BIT,
      SSSP_MODE_CONT,
      SSSP_MODE_RSVD
   } sssp_mode_t;

   typedef struct packed {
      logic level;
      logic rise;
      logic fall;
   } sssp_tick_t;

endpackage

// ==== src/sssp_prescaler.sv ====
`timescale 1ns/1ps
module sssp_prescaler #(
   parameter int CNT_W = sssp_pkg::PRESC_W
) (
   input  wire logic                             core_clk,
   input  wire logic                             sys_rst,
   input  wire logic                             clear,
   input  wire logic [sssp_pkg::CTRL_DIV_W-1:0]  sel,
   output sssp_pkg::sssp_tick_t                  tick
);

   if (CNT_W < 10) begin : g_chk
      $error("sssp_prescaler: counter too narrow for divide by 1024");
   end

   logic [CNT_W-1:0] cnt_reg;
   logic             tap_prev_reg;
   logic [3:0]       tap_idx;
   logic             tap_level;

   assign tap_idx   = sssp_pkg::TAP_BITS[{2'b00, sel} * 4 +: 4];
   assign tap_level = cnt_reg[tap_idx];

   // free running; cleared on control writes so the first period is whole
   always_ff @(posedge core_clk) begin
      if (sys_rst || clear) begin
         cnt_reg      <= '0;
         tap_prev_reg <= 1'b0;
      end else begin
         cnt_reg      <= cnt_reg + 1'b1;
         tap_prev_reg <= tap_level;
      end
   end

   assign tick.level = tap_level;
   assign tick.rise  = tap_level & ~tap_prev_reg;
   assign tick.fall  = ~tap_level & tap_prev_reg;

endmodule // sssp_prescaler

// ==== src/sssp_top.sv ====
`timescale 1ns/1ps
module sssp_top #(
   parameter int PADDR_W = 32
) (
   input  wire logic               core_clk,
   input  wire logic               sys_rst,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [PADDR_W-1:0] paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               serial_clock_pin_in,
   output logic                    serial_clock_pin_out,
   output logic                    serial_clock_pin_oe,
   input  wire logic               serial_in_pin,
   output logic                    serial_out_pin,
   output logic                    irq
);

   if (PADDR_W < 18 || PADDR_W > 32) begin : g_chk
      $error("sssp_top: address width must cover the register indices");
   end

   // ---------------- registers ----------------
   logic [7:0]                  ctrl_reg;
   logic [7:0]                  data_upper_reg;
   logic [7:0]                  data_lower_reg;
   logic                        busy_reg;
   logic                        overrun_reg;
   logic                        ovr_seen_reg;
   logic                        spare_reg;
   logic                        so_reg;
   logic                        sck_reg;
   logic                        sck_oe_reg;
   logic [4:0]                  bit_cnt_reg;
   logic [sssp_pkg::INT_W-1:0]  int_status_reg;
   logic [sssp_pkg::INT_W-1:0]  int_mask_reg;
   logic                        irq_reg;
   logic                        pready_reg;
   logic                        pslverr_reg;
   logic [31:0]                 prdata_reg;
   logic [1:0]                  sck_sync_reg;
   logic [1:0]                  si_sync_reg;
   logic                        sck_prev_reg;

   // ---------------- decode ----------------
   logic                        acc;
   logic                        wr;
   logic                        rd;
   logic [PADDR_W-1:0]          a_ctrl;
   logic [PADDR_W-1:0]          a_sts;
   logic [PADDR_W-1:0]          a_up;
   logic [PADDR_W-1:0]          a_lo;
   logic [PADDR_W-1:0]          a_ist;
   logic [PADDR_W-1:0]          a_imk;
   logic                        hit_ctrl;
   logic                        hit_sts;
   logic                        hit_up;
   logic                        hit_lo;
   logic                        hit_ist;
   logic                        hit_imk;
   logic                        hit_any;
   logic                        wr_ctrl;
   logic                        wr_sts;
   logic [7:0]                  sts_view;
   logic [31:0]                 rd_mux;

   assign a_ctrl   = PADDR_W'({sssp_pkg::IDX_MODE_CLOCK_CTRL, 2'b00});
   assign a_sts    = PADDR_W'({sssp_pkg::IDX_CTRL_STATUS, 2'b00});
   assign a_up     = PADDR_W'({sssp_pkg::IDX_DATA_UPPER, 2'b00});
   assign a_lo     = PADDR_W'({sssp_pkg::IDX_DATA_LOWER, 2'b00});
   assign a_ist    = PADDR_W'({sssp_pkg::IDX_INT_STATUS, 2'b00});
   assign a_imk    = PADDR_W'({sssp_pkg::IDX_INT_MASK, 2'b00});
   // one wait state: the answer is taken while pready_reg is high
   assign acc      = psel & penable & pready_reg;
   assign wr       = acc & pwrite;
   assign rd       = acc & ~pwrite;
   assign hit_ctrl = (paddr == a_ctrl);
   assign hit_sts  = (paddr == a_sts);
   assign hit_up   = (paddr == a_up);
   assign hit_lo   = (paddr == a_lo);
   assign hit_ist  = (paddr == a_ist);
   assign hit_imk  = (paddr == a_imk);
   assign hit_any  = hit_ctrl | hit_sts | hit_up | hit_lo | hit_ist | hit_imk;
   assign wr_ctrl  = wr & hit_ctrl;
   assign wr_sts   = wr & hit_sts;

   assign sts_view = sssp_pkg::STATUS_FIXED
                   | (8'(so_reg) << sssp_pkg::STS_LEVEL)
                   | (8'(overrun_reg) << sssp_pkg::STS_OVERRUN)
                   | (8'(spare_reg) << sssp_pkg::STS_SPARE)
                   | (8'(busy_reg) << sssp_pkg::STS_START);

   assign rd_mux = hit_ctrl ? {24'h000000, ctrl_reg} :
                   hit_sts  ? {24'h000000, sts_view} :
                   hit_up   ? {24'h000000, data_upper_reg} :
                   hit_lo   ? {24'h000000, data_lower_reg} :
                   hit_ist  ? {30'h00000000, int_status_reg} :
                   hit_imk  ? {30'h00000000, int_mask_reg} : 32'h00000000;

   // ---------------- mode and clock selection ----------------
   sssp_pkg::sssp_mode_t mode;
   sssp_pkg::sssp_tick_t ptick;
   logic                 ext_clk;
   logic                 is16;
   logic                 xfer_mode;
   logic [4:0]           last_bit;
   logic                 ext_rise;
   logic                 ext_fall;
   logic                 edge_rise;
   logic                 edge_fall;
   logic                 start_req;
   logic                 done;

   assign mode      = sssp_pkg::sssp_mode_t'({ctrl_reg[sssp_pkg::CTRL_MODE_HI], ctrl_reg[sssp_pkg::CTRL_MODE_LO]});
   assign ext_clk   = ctrl_reg[sssp_pkg::CTRL_SRC];
   assign is16      = (mode == sssp_pkg::SSSP_MODE_16BIT);
   // reserved mode 11 is treated as idle; software must not use it
   assign xfer_mode = (mode == sssp_pkg::SSSP_MODE_8BIT) || is16;
   assign last_bit  = (is16 ? sssp_pkg::LEN_16 : sssp_pkg::LEN_8) - 5'h01;

   sssp_prescaler u_presc (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .clear    (wr_ctrl),
      .sel      (ctrl_reg[sssp_pkg::CTRL_DIV_LO +: sssp_pkg::CTRL_DIV_W]),
      .tick     (ptick)
   );

   // edge detection reads only the second synchroniser stage
   assign ext_rise  = sck_sync_reg[1] & ~sck_prev_reg;
   assign ext_fall  = ~sck_sync_reg[1] & sck_prev_reg;
   // internal edges follow the pin we drive, so the first edge is a fall
   assign edge_fall = ext_clk ? ext_fall : (ptick.fall & sck_reg);
   assign edge_rise = ext_clk ? ext_rise : (ptick.rise & ~sck_reg);
   assign start_req = wr_sts & pwdata[sssp_pkg::STS_START] & xfer_mode;
   assign done      = busy_reg & edge_rise & (bit_cnt_reg == last_bit) & ~wr_ctrl;

   // ---------------- pin synchronisers ----------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sck_sync_reg <= 2'h3;
         si_sync_reg  <= 2'h0;
         sck_prev_reg <= 1'b1;
      end else begin
         sck_sync_reg <= {sck_sync_reg[0], serial_clock_pin_in};
         si_sync_reg  <= {si_sync_reg[0], serial_in_pin};
         sck_prev_reg <= sck_sync_reg[1];
      end
   end

   // ---------------- control register ----------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl_reg <= sssp_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg <= pwdata[7:0];
      end
   end

   // ---------------- transfer engine ----------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         busy_reg    <= 1'b0;
         bit_cnt_reg <= 5'h00;
      end else if (wr_ctrl) begin
         busy_reg    <= 1'b0;
         bit_cnt_reg <= 5'h00;
      end else if (done) begin
         busy_reg    <= 1'b0;
         bit_cnt_reg <= 5'h00;
      end else if (busy_reg && edge_rise) begin
         bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end else if (!busy_reg && start_req) begin
         busy_reg    <= 1'b1;
         bit_cnt_reg <= 5'h00;
      end
   end

   // shift on rising edge: lower takes upper lsb in 16-bit, input enters at top
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         data_upper_reg <= sssp_pkg::DATA_RESET;
         data_lower_reg <= sssp_pkg::DATA_RESET;
      end else if (busy_reg && edge_rise && !wr_ctrl) begin
         if (is16) begin
            data_upper_reg <= {si_sync_reg[1], data_upper_reg[7:1]};
            data_lower_reg <= {data_upper_reg[0], data_lower_reg[7:1]};
         end else begin
            data_lower_reg <= {si_sync_reg[1], data_lower_reg[7:1]};
         end
      end else if (wr && hit_up) begin
         data_upper_reg <= pwdata[7:0];
      end else if (wr && hit_lo) begin
         data_lower_reg <= pwdata[7:0];
      end
   end

   // output bit changes on falling edge and holds the last bit after completion
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         so_reg    <= 1'b0;
         spare_reg <= 1'b0;
      end else begin
         if (busy_reg && edge_fall && !wr_ctrl) begin
            so_reg <= data_lower_reg[0];
         end else if (wr_sts) begin
            so_reg <= pwdata[sssp_pkg::STS_LEVEL];
         end
         if (wr_sts) begin
            spare_reg <= pwdata[sssp_pkg::STS_SPARE];
         end
      end
   end

   // ---------------- serial clock pin ----------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sck_reg    <= 1'b1;
         sck_oe_reg <= 1'b1;
      end else begin
         sck_oe_reg <= ~ext_clk;
         if (mode == sssp_pkg::SSSP_MODE_CONT) begin
            sck_reg <= ptick.level;
         end else if (wr_ctrl || done || !busy_reg || ext_clk) begin
            sck_reg <= 1'b1;
         end else if (ptick.fall) begin
            sck_reg <= 1'b0;
         end else if (ptick.rise) begin
            sck_reg <= 1'b1;
         end
      end
   end

   // ---------------- overrun flag ----------------
   logic ovr_event;
   logic ovr_clear;

   // a rising external clock while idle in mode 00 or 01 is an overrun
   assign ovr_event = ext_clk & xfer_mode & ~busy_reg & ext_rise;
   assign ovr_clear = wr_sts & ~pwdata[sssp_pkg::STS_OVERRUN] & ovr_seen_reg;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         overrun_reg  <= 1'b0;
         ovr_seen_reg <= 1'b0;
      end else begin
         if (ovr_event) begin
            overrun_reg <= 1'b1;
         end else if (ovr_clear) begin
            overrun_reg <= 1'b0;
         end
         if (rd && hit_sts && overrun_reg) begin
            ovr_seen_reg <= 1'b1;
         end else if (ovr_clear || !overrun_reg) begin
            ovr_seen_reg <= 1'b0;
         end
      end
   end

   // ---------------- interrupts ----------------
   logic [sssp_pkg::INT_W-1:0] int_set;
   logic [sssp_pkg::INT_W-1:0] int_clr;

   assign int_set = sssp_pkg::INT_W'({ovr_event, done});
   assign int_clr = (wr && hit_ist) ? pwdata[sssp_pkg::INT_W-1:0] : '0;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         int_status_reg <= '0;
         int_mask_reg   <= '0;
         irq_reg        <= 1'b0;
      end else begin
         // set beats a simultaneous write-one clear
         int_status_reg <= (int_status_reg & ~int_clr) | int_set;
         if (wr && hit_imk) begin
            int_mask_reg <= pwdata[sssp_pkg::INT_W-1:0];
         end
         irq_reg <= |(int_status_reg & int_mask_reg);
      end
   end

   // ---------------- apb answer ----------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h00000000;
      end else begin
         pready_reg  <= psel & penable & ~pready_reg;
         pslverr_reg <= psel & penable & ~pready_reg & ~hit_any;
         prdata_reg  <= (psel & penable & ~pwrite) ? rd_mux : 32'h00000000;
      end
   end

   assign prdata               = prdata_reg;
   assign pready               = pready_reg;
   assign pslverr              = pslverr_reg;
   assign serial_clock_pin_out = sck_reg;
   assign serial_clock_pin_oe  = sck_oe_reg;
   assign serial_out_pin       = so_reg;
   assign irq                  = irq_reg;

endmodule // sssp_top

// ==== testbench/sssp_top_properties.sv ====
`timescale 1ns/1ps
module sssp_top_properties #(
   parameter int PADDR_W = 32
) (
   input wire logic               core_clk,
   input wire logic               sys_rst,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0]        pwdata,
   input wire logic [31:0]        prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire logic               serial_clock_pin_in,
   input wire logic               serial_clock_pin_out,
   input wire logic               serial_clock_pin_oe,
   input wire logic               serial_in_pin,
   input wire logic               serial_out_pin,
   input wire logic               irq
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   // shadow of the control register, so readback and pin direction can be judged
   logic [7:0] ctl_shadow;
   wire        xfer   = psel && penable && pready;
   wire [15:0] idx    = paddr[17:2];
   wire        mapped = paddr[1:0] == 2'h0 && paddr[PADDR_W-1:18] == '0 && idx >= sssp_pkg::IDX_MODE_CLOCK_CTRL
                        && idx <= sssp_pkg::IDX_INT_MASK;
   wire        ctl_wr = xfer && pwrite && mapped && idx == sssp_pkg::IDX_MODE_CLOCK_CTRL;
   wire        ctl_rd = xfer && !pwrite && mapped && idx == sssp_pkg::IDX_MODE_CLOCK_CTRL;
   wire        msk_off = xfer && pwrite && idx == sssp_pkg::IDX_INT_MASK && pwdata[1:0] == 2'h0;
   wire        cont_fast = ctl_wr && pwdata[7:6] == 2'h2 && pwdata[3:0] == 4'h7;

   always_ff @(posedge core_clk) begin
      ctl_shadow <= sys_rst ? sssp_pkg::CTRL_RESET : (ctl_wr ? pwdata[7:0] : ctl_shadow);
   end

   a_one_wait:      assert property ($rose(penable) && psel |-> !pready ##1 pready)
                    else $error("pready not on second access cycle");
   a_ready_access:  assert property (pready |-> psel && penable)
                    else $error("pready outside access phase");
   a_err_decode:    assert property (xfer |-> pslverr == !mapped)
                    else $error("pslverr disagrees with address map");
   a_unmapped_zero: assert property (xfer && !pwrite && !mapped |-> prdata == 32'h00000000)
                    else $error("unmapped read not zero");
   a_ctl_readback:  assert property (ctl_rd |-> prdata == {24'h000000, ctl_shadow})
                    else $error("control readback wrong");
   a_pin_dir:       assert property (ctl_wr |-> ##2 serial_clock_pin_oe == !ctl_shadow[3])
                    else $error("clock pin direction wrong");
   a_abort_idle:    assert property (ctl_wr && !pwdata[7] && !pwdata[3] |-> ##2 serial_clock_pin_out[*2])
                    else $error("clock not idle after control write");
   a_clock_rests:   assert property ($rose(irq) && serial_clock_pin_oe |-> serial_clock_pin_out[*4])
                    else $error("clock moved after completion");
   a_masked_quiet:  assert property (msk_off |-> ##2 !irq[*3])
                    else $error("irq high with all masked");
   a_cont_runs:     assert property (cont_fast |-> ##[2:12] $changed(serial_clock_pin_out))
                    else $error("continuous clock not running");
endmodule // sssp_top_properties

bind sssp_top sssp_top_properties #(.PADDR_W(PADDR_W)) sssp_top_properties_inst (
   .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .serial_clock_pin_in(serial_clock_pin_in), .serial_clock_pin_out(serial_clock_pin_out),
   .serial_clock_pin_oe(serial_clock_pin_oe), .serial_in_pin(serial_in_pin),
   .serial_out_pin(serial_out_pin), .irq(irq));

// ==== testbench/sssp_peer.sv ====
`timescale 1ns/1ps
// far-side shifter; its own clock idles high and uses 8-cycle halves, wide enough for the 2FF sync
module sssp_peer (
   input  wire logic        core_clk,
   input  wire logic        go,
   input  wire logic [15:0] tx,
   input  wire logic [4:0]  pulses,
   input  wire logic        sck,
   input  wire logic        so,
   output logic             ext_sck,
   output logic             si,
   output logic [15:0]      rx
);
   logic [15:0] sh = 16'h0000;
   logic [15:0] rx_q = 16'h0000;
   logic [4:0]  n = 5'h00;
   logic [2:0]  cnt = 3'h0;
   logic        ck_q = 1'b1;
   logic        si_q = 1'b0;
   logic        sck_q = 1'b1;
   assign ext_sck = ck_q;
   assign si = si_q;
   assign rx = rx_q;
   always @(posedge core_clk) begin
      sck_q <= sck;
      if (sck_q && !sck) begin
         si_q <= sh[0];
         sh <= sh >> 1;
      end
      if (!sck_q && sck) begin
         rx_q <= {so, rx_q[15:1]};
      end
      if (go) begin
         sh <= tx;
         n <= pulses;
         cnt <= 3'h0;
      end else if (n != 5'h00) begin
         cnt <= cnt + 3'h1;
         if (cnt == 3'h7) begin
            ck_q <= !ck_q;
            n <= ck_q ? n : n - 5'h01;
         end
      end
   end
endmodule // sssp_peer

// ==== testbench/sssp_top_bench.sv ====
`timescale 1ns/1ps
module sssp_top_bench;
   localparam logic [15:0] r_ctl = sssp_pkg::IDX_MODE_CLOCK_CTRL;
   localparam logic [15:0] r_sts = sssp_pkg::IDX_CTRL_STATUS;
   localparam logic [15:0] r_up  = sssp_pkg::IDX_DATA_UPPER;
   localparam logic [15:0] r_lo  = sssp_pkg::IDX_DATA_LOWER;
   localparam logic [15:0] r_int = sssp_pkg::IDX_INT_STATUS;
   localparam logic [15:0] r_msk = sssp_pkg::IDX_INT_MASK;
   localparam int          divs [8] = '{1024, 256, 64, 32, 16, 8, 4, 2};
   logic        core_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] paddr = 32'h00000000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, q;
   logic        pready, pslverr, err, sck_out, sck_oe, so, irq, ext_sck, si;
   logic        go = 1'b0;
   logic        sp = 1'b1;
   logic [15:0] tx = 16'h0000;
   logic [15:0] rx;
   logic [4:0]  pulses = 5'h00;
   wire         sck = sck_oe ? sck_out : ext_sck;
   int          fail_count = 0;
   int          checks_done = 0;
   int          falls = 0;

   initial forever #12.5 core_clk = ~core_clk;

   sssp_top sssp_top_inst (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_clock_pin_in(sck), .serial_clock_pin_out(sck_out), .serial_clock_pin_oe(sck_oe),
      .serial_in_pin(si), .serial_out_pin(so), .irq(irq));
   sssp_peer sssp_peer_inst (.core_clk(core_clk), .go(go), .tx(tx), .pulses(pulses), .sck(sck), .so(so),
      .ext_sck(ext_sck), .si(si), .rx(rx));

   always @(posedge core_clk) begin
      sp <= sck_out;
      if (sp === 1'b1 && sck_out === 1'b0) falls <= falls + 1;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic miss(input string what);
      fail_count++;
      $display("MISMATCH t=%0t timeout %s", $time, what);
      give_verdict();
   endtask

   // entered just after a rising edge; leaves one idle cycle behind
   task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {14'h0000, idx, 2'h0};
      pwdata <= {24'h000000, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) miss("apb");
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [15:0] idx, input logic [31:0] m, input logic [31:0] exp, input string what);
      apb(1'b0, idx, 8'h00);
      chk(q & m, exp, what);
   endtask

   task automatic wait_irq();
      int k;
      for (k = 0; k < 4000 && irq !== 1'b1; k++) @(posedge core_clk);
      if (k >= 4000) miss("irq");
   endtask

   // counts cycles up to the next falling clock edge
   task automatic wait_fall(output int n);
      logic p;
      p = sck_out;
      for (n = 1; n < 2100; n++) begin
         @(posedge core_clk);
         if (p === 1'b1 && sck_out === 1'b0) break;
         p = sck_out;
      end
      if (n >= 2100) miss("fall");
   endtask

   task automatic peer_go(input logic [15:0] t, input logic [4:0] np);
      tx <= t;
      pulses <= np;
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
   endtask

   task automatic t_regs();
      rd(r_ctl, 32'hFFFFFFFF, 32'h00000000, "ctrl reset");
      rd(r_sts, 32'hFFFFFFFF, 32'h00000080, "status reset");
      rd(r_lo, 32'hFFFFFFFF, 32'h00000000, "lower reset");
      apb(1'b1, r_ctl, 8'h38);
      rd(r_ctl, 32'hFFFFFFFF, 32'h00000038, "spare bits kept");
      chk(32'(sck_oe), 32'h00000000, "clock pin input");
      apb(1'b1, r_ctl, 8'h04);
      rd(r_sts, 32'h00000001, 32'h00000000, "idle");
      chk(32'(sck_oe), 32'h00000001, "clock pin output");
      apb(1'b0, 16'hFFA6, 8'h00);
      chk(q, 32'h00000000, "unmapped data");
      chk(32'(err), 32'h00000001, "unmapped error");
      $display("test regs done");
   endtask

   // internal clock /16 transfer of mode 00 or 01
   task automatic t_xfer(input logic [7:0] c, input logic [15:0] wd, input logic [15:0] pd, input int nb);
      int f0;
      apb(1'b1, r_msk, 8'h03);
      apb(1'b1, r_ctl, c);
      apb(1'b1, r_up, wd[15:8]);
      apb(1'b1, r_lo, wd[7:0]);
      peer_go(pd, 5'h00);
      // falls is owned by the edge counter; take a baseline instead of clearing it
      f0 = falls;
      apb(1'b1, r_sts, 8'h01);
      rd(r_sts, 32'h00000001, 32'h00000001, "busy");
      wait_irq();
      rd(r_sts, 32'h00000001, 32'h00000000, "done");
      chk(32'(falls - f0), 32'(nb), "clock count");
      rd(r_lo, 32'h000000FF, {24'h000000, pd[7:0]}, "lower rx");
      if (nb == 16) rd(r_up, 32'h000000FF, {24'h000000, pd[15:8]}, "upper rx");
      // the output pin keeps showing the last bit sent once the word is done
      chk(32'(so), 32'(nb == 16 ? wd[15] : wd[7]), "last bit held");
      chk({16'h0000, nb == 16 ? rx : {rx[15:8], 8'h00}}, {16'h0000, nb == 16 ? wd : {wd[7:0], 8'h00}},
          "peer rx");
      apb(1'b1, r_int, 8'h01);
      rd(r_int, 32'h00000003, 32'h00000000, "int cleared");
      chk(32'(irq), 32'h00000000, "irq cleared");
      $display("test transfer %0d done", nb);
   endtask

   task automatic t_abort();
      int k;
      int f0;
      apb(1'b1, r_ctl, 8'h04);
      f0 = falls;
      apb(1'b1, r_sts, 8'h01);
      for (k = 0; k < 500 && falls - f0 < 3; k++) @(posedge core_clk);
      if (k >= 500) miss("abort");
      apb(1'b1, r_ctl, 8'h04);
      rd(r_sts, 32'h00000001, 32'h00000000, "aborted");
      chk(32'(sck_out), 32'h00000001, "clock idle");
      $display("test abort done");
   endtask

   task automatic t_ext();
      apb(1'b1, r_ctl, 8'h08);
      apb(1'b1, r_lo, 8'h5A);
      apb(1'b1, r_sts, 8'h01);
      peer_go(16'h00C3, 5'h08);
      wait_irq();
      rd(r_lo, 32'h000000FF, 32'h000000C3, "ext rx");
      chk({24'h000000, rx[15:8]}, 32'h0000005A, "ext tx");
      apb(1'b1, r_int, 8'h01);
      peer_go(16'h0000, 5'h01);
      wait_irq();
      rd(r_sts, 32'h00000020, 32'h00000020, "overrun set");
      apb(1'b1, r_sts, 8'h00);
      rd(r_sts, 32'h00000020, 32'h00000000, "overrun cleared");
      apb(1'b1, r_msk, 8'h00);
      rd(r_int, 32'h00000003, 32'h00000002, "overrun event");
      chk(32'(irq), 32'h00000000, "masked");
      apb(1'b1, r_msk, 8'h03);
      rd(r_msk, 32'h00000003, 32'h00000003, "mask back");
      chk(32'(irq), 32'h00000001, "unmasked");
      apb(1'b1, r_int, 8'h02);
      rd(r_int, 32'h00000003, 32'h00000000, "event cleared");
      chk(32'(irq), 32'h00000000, "irq off");
      $display("test external done");
   endtask

   task automatic t_cont();
      int n;
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, r_ctl, 8'h80 | 8'(c));
         wait_fall(n);
         wait_fall(n);
         chk(32'(n), 32'(divs[c]), "divider period");
      end
      apb(1'b1, r_ctl, 8'h00);
      $display("test continuous done");
   endtask

   initial begin
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      t_regs();
      t_xfer(8'h04, 16'h00A5, 16'h003C, 8);
      t_xfer(8'h44, 16'h1234, 16'hBEEF, 16);
      t_abort();
      t_ext();
      t_cont();
      give_verdict();
   end
endmodule // sssp_top_bench
